/* common/demand_mon_pkg.sv */
package demand_mon_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DUTY_LIM = 8'h04;
  localparam logic [7:0] OFS_FREQ_MIN = 8'h08;
  localparam logic [7:0] OFS_FREQ_MAX = 8'h0c;
  localparam logic [7:0] OFS_TRK_DIFF = 8'h10;
  localparam logic [7:0] OFS_TRK_TIME = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFS_MEAS_PERIOD = 8'h24;
  localparam logic [7:0] OFS_MEAS_HIGH = 8'h28;

  // control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DUAL_BIT = 1;
  // duty limit fields, duty in 1/256 of the period
  localparam int DUTY_MIN_LSB = 0;
  localparam int DUTY_MAX_LSB = 8;
  localparam int DUTY_W = 8;
  localparam int DUTY_FRAC_BITS = 8;

  // reset values
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [7:0] DUTY_MIN_RST = 8'h0d;
  localparam logic [7:0] DUTY_MAX_RST = 8'hf3;
  localparam logic [15:0] FREQ_MIN_RST = 16'h01f4;
  localparam logic [15:0] FREQ_MAX_RST = 16'h0bb8;
  localparam logic [15:0] TRK_DIFF_RST = 16'h0100;
  localparam logic [15:0] TRK_TIME_RST = 16'h0064;
  localparam logic [5:0] MASK_RST = 6'h00;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [39:0] CLK_HZ = 40'h0005f5e100;
  localparam int TRK_TICK_NS = 1000000;
  localparam int TRK_TICK_CYCLES = TRK_TICK_NS / CLK_PERIOD_NS;

  // widths
  localparam int PERIOD_W = 24;
  localparam int POS_W = 16;
  localparam int NFLAGS = 6;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // diagnostic flags, bit order matches the status and mask layout
  typedef struct packed {
    logic tracking;
    logic speed;
    logic freq_lo;
    logic freq_hi;
    logic duty_lo;
    logic duty_hi;
  } diag_flags_t;

endpackage

/* rtl/demand_mon.sv */
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module demand_mon #(
  parameter int unsigned TICK_CYCLES = demand_mon_pkg::TRK_TICK_CYCLES,
  parameter int PERIOD_W = demand_mon_pkg::PERIOD_W,
  parameter int POS_W = demand_mon_pkg::POS_W
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire demand_mon_pkg::reg_req_t i_req,
  output logic [31:0] o_rdata,
  input wire logic i_pwm,
  input wire logic [POS_W-1:0] i_can1_pos,
  input wire logic [POS_W-1:0] i_can2_pos,
  input wire logic [POS_W-1:0] i_analog_pos,
  output demand_mon_pkg::diag_flags_t o_flags,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [1:0] ctrl_q;
  logic [7:0] duty_min_q;
  logic [7:0] duty_max_q;
  logic [15:0] freq_min_q;
  logic [15:0] freq_max_q;
  logic [15:0] trk_diff_q;
  logic [15:0] trk_time_q;
  logic [5:0] irq_mask_q;
  logic [5:0] irq_status_q;
  demand_mon_pkg::diag_flags_t flags_q;
  logic [5:0] flags_prev_q;
  logic mon_en;
  logic dual_can;

  assign mon_en = ctrl_q[demand_mon_pkg::CTRL_EN_BIT];
  assign dual_can = ctrl_q[demand_mon_pkg::CTRL_DUAL_BIT];

  // software writes; unmapped or read-only offsets are ignored
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= demand_mon_pkg::CTRL_RST;
      duty_min_q <= demand_mon_pkg::DUTY_MIN_RST;
      duty_max_q <= demand_mon_pkg::DUTY_MAX_RST;
      freq_min_q <= demand_mon_pkg::FREQ_MIN_RST;
      freq_max_q <= demand_mon_pkg::FREQ_MAX_RST;
      trk_diff_q <= demand_mon_pkg::TRK_DIFF_RST;
      trk_time_q <= demand_mon_pkg::TRK_TIME_RST;
      irq_mask_q <= demand_mon_pkg::MASK_RST;
    end else if (i_clk_en && i_req.wr) begin
      if (i_req.addr == demand_mon_pkg::OFS_CTRL) begin
        ctrl_q <= i_req.wdata[1:0];
      end else if (i_req.addr == demand_mon_pkg::OFS_DUTY_LIM) begin
        duty_min_q <= i_req.wdata[demand_mon_pkg::DUTY_MIN_LSB +: 8];
        duty_max_q <= i_req.wdata[demand_mon_pkg::DUTY_MAX_LSB +: 8];
      end else if (i_req.addr == demand_mon_pkg::OFS_FREQ_MIN) begin
        freq_min_q <= i_req.wdata[15:0];
      end else if (i_req.addr == demand_mon_pkg::OFS_FREQ_MAX) begin
        freq_max_q <= i_req.wdata[15:0];
      end else if (i_req.addr == demand_mon_pkg::OFS_TRK_DIFF) begin
        trk_diff_q <= i_req.wdata[15:0];
      end else if (i_req.addr == demand_mon_pkg::OFS_TRK_TIME) begin
        trk_time_q <= i_req.wdata[15:0];
      end else if (i_req.addr == demand_mon_pkg::OFS_IRQ_MASK) begin
        irq_mask_q <= i_req.wdata[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pwm measurement: period and high time in core clocks, rise to rise

  logic pwm_prev_q;
  logic [PERIOD_W-1:0] per_cnt_q;
  logic [PERIOD_W-1:0] hi_cnt_q;
  logic [PERIOD_W-1:0] meas_per_q;
  logic [PERIOD_W-1:0] meas_hi_q;
  logic meas_valid_q;
  logic pwm_rise;
  logic per_sat;
  logic meas_take;

  assign pwm_rise = i_pwm && !pwm_prev_q;
  // a stuck input runs the counter to all ones, which yields a measurement and restarts it,
  // so a dead signal reads as very low frequency instead of freezing
  assign per_sat = &per_cnt_q;
  assign meas_take = pwm_rise || per_sat;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pwm_prev_q <= 1'b0;
    end else if (i_clk_en) begin
      pwm_prev_q <= i_pwm;
    end
  end

  // counters restart at each measurement; the first counted cycle is 1
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      per_cnt_q <= '0;
      hi_cnt_q <= '0;
    end else if (i_clk_en) begin
      if (meas_take) begin
        per_cnt_q <= PERIOD_W'(1);
        hi_cnt_q <= PERIOD_W'(i_pwm);
      end else begin
        per_cnt_q <= per_cnt_q + PERIOD_W'(1);
        hi_cnt_q <= hi_cnt_q + PERIOD_W'(i_pwm);
      end
    end
  end

  // latch the finished measurement; only a rise in the first cycle after reset is skipped
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meas_per_q <= '0;
      meas_hi_q <= '0;
      meas_valid_q <= 1'b0;
    end else if (i_clk_en) begin
      meas_valid_q <= 1'b0;
      if (meas_take && per_cnt_q != '0) begin
        meas_per_q <= per_cnt_q;
        meas_hi_q <= hi_cnt_q;
        meas_valid_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // limit comparisons, done by cross multiplication to avoid a divider

  localparam int PW = PERIOD_W + 16;
  logic [PW-1:0] hi_scaled;
  logic [PW-1:0] duty_max_prod;
  logic [PW-1:0] duty_min_prod;
  logic [PW-1:0] fmax_prod;
  logic [PW-1:0] fmin_prod;
  logic [PW-1:0] clk_hz;

  assign hi_scaled = PW'(meas_hi_q) << demand_mon_pkg::DUTY_FRAC_BITS;
  assign duty_max_prod = PW'(duty_max_q) * PW'(meas_per_q);
  assign duty_min_prod = PW'(duty_min_q) * PW'(meas_per_q);
  assign fmax_prod = PW'(freq_max_q) * PW'(meas_per_q);
  assign fmin_prod = PW'(freq_min_q) * PW'(meas_per_q);
  assign clk_hz = PW'(demand_mon_pkg::CLK_HZ);

  // pwm flags follow each new measurement, set and cleared alike
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flags_q.duty_hi <= 1'b0;
      flags_q.duty_lo <= 1'b0;
      flags_q.freq_hi <= 1'b0;
      flags_q.freq_lo <= 1'b0;
    end else if (i_clk_en) begin
      if (!mon_en) begin
        flags_q.duty_hi <= 1'b0;
        flags_q.duty_lo <= 1'b0;
        flags_q.freq_hi <= 1'b0;
        flags_q.freq_lo <= 1'b0;
      end else if (meas_valid_q) begin
        flags_q.duty_hi <= hi_scaled > duty_max_prod;
        flags_q.duty_lo <= hi_scaled < duty_min_prod;
        flags_q.freq_hi <= clk_hz > fmax_prod;
        flags_q.freq_lo <= clk_hz < fmin_prod;
      end
    end
  end

  // no speed sensor input exists in this block
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flags_q.speed <= 1'b0;
    end else if (i_clk_en) begin
      flags_q.speed <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tracking alarm: persistence timer in ticks of TICK_CYCLES clocks

  logic [POS_W-1:0] ref_pos;
  logic [POS_W-1:0] abs_diff;
  logic diff_over;
  logic [31:0] pre_q;
  logic tick;
  logic [16:0] trk_cnt_q;

  assign ref_pos = dual_can ? i_can2_pos : i_analog_pos;
  assign abs_diff = (i_can1_pos >= ref_pos) ? i_can1_pos - ref_pos
                                            : ref_pos - i_can1_pos;
  assign diff_over = abs_diff > POS_W'(trk_diff_q);
  assign tick = pre_q == TICK_CYCLES - 1;

  // the prescaler restarts with the timer, so the first tick is a full one
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_q <= '0;
    end else if (i_clk_en) begin
      if (!diff_over || !mon_en || tick) begin
        pre_q <= '0;
      end else begin
        pre_q <= pre_q + 32'h1;
      end
    end
  end

  // count ticks while over the limit; any cycle within the limit restarts
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      trk_cnt_q <= '0;
      flags_q.tracking <= 1'b0;
    end else if (i_clk_en) begin
      if (!diff_over || !mon_en) begin
        trk_cnt_q <= '0;
        flags_q.tracking <= 1'b0;
      end else begin
        if (tick && !(&trk_cnt_q)) begin
          trk_cnt_q <= trk_cnt_q + 17'h1;
        end
        flags_q.tracking <= trk_cnt_q > {1'b0, trk_time_q};
      end
    end
  end

  assign o_flags = flags_q;

  ////////////////////////////////////////////////////////////////////////
  // interrupt: rising flags set sticky bits, write one to clear

  logic [5:0] flags_vec;
  logic [5:0] w1c;

  assign flags_vec = flags_q;
  assign w1c = (i_req.wr && i_req.addr == demand_mon_pkg::OFS_IRQ_STATUS)
               ? i_req.wdata[5:0] : 6'h00;

  // a set arriving with a clear wins, so no event is lost
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flags_prev_q <= '0;
      irq_status_q <= '0;
    end else if (i_clk_en) begin
      flags_prev_q <= flags_vec;
      irq_status_q <= (irq_status_q & ~w1c) | (flags_vec & ~flags_prev_q);
    end
  end

  assign o_irq = |(irq_status_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe; unmapped reads give zero

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= '0;
    end else if (i_clk_en) begin
      o_rdata <= '0;
      if (i_req.rd) begin
        if (i_req.addr == demand_mon_pkg::OFS_CTRL) begin
          o_rdata <= {30'h0, ctrl_q};
        end else if (i_req.addr == demand_mon_pkg::OFS_DUTY_LIM) begin
          o_rdata <= {16'h0, duty_max_q, duty_min_q};
        end else if (i_req.addr == demand_mon_pkg::OFS_FREQ_MIN) begin
          o_rdata <= {16'h0, freq_min_q};
        end else if (i_req.addr == demand_mon_pkg::OFS_FREQ_MAX) begin
          o_rdata <= {16'h0, freq_max_q};
        end else if (i_req.addr == demand_mon_pkg::OFS_TRK_DIFF) begin
          o_rdata <= {16'h0, trk_diff_q};
        end else if (i_req.addr == demand_mon_pkg::OFS_TRK_TIME) begin
          o_rdata <= {16'h0, trk_time_q};
        end else if (i_req.addr == demand_mon_pkg::OFS_FLAGS) begin
          o_rdata <= {26'h0, flags_vec};
        end else if (i_req.addr == demand_mon_pkg::OFS_IRQ_STATUS) begin
          o_rdata <= {26'h0, irq_status_q};
        end else if (i_req.addr == demand_mon_pkg::OFS_IRQ_MASK) begin
          o_rdata <= {26'h0, irq_mask_q};
        end else if (i_req.addr == demand_mon_pkg::OFS_MEAS_PERIOD) begin
          o_rdata <= 32'(meas_per_q);
        end else if (i_req.addr == demand_mon_pkg::OFS_MEAS_HIGH) begin
          o_rdata <= 32'(meas_hi_q);
        end
      end
    end
  end

endmodule // demand_mon

/* tb/demand_mon_asserts.sv */
`timescale 1ns/10ps
module demand_mon_asserts #(
  parameter int unsigned TICK_CYCLES = 4,
  parameter int PERIOD_W = 24,
  parameter int POS_W = 16
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire demand_mon_pkg::reg_req_t i_req,
  input wire logic [31:0] o_rdata,
  input wire logic i_pwm,
  input wire logic [POS_W-1:0] i_can1_pos,
  input wire logic [POS_W-1:0] i_can2_pos,
  input wire logic [POS_W-1:0] i_analog_pos,
  input wire demand_mon_pkg::diag_flags_t o_flags,
  input wire logic o_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  logic neq;
  logic [7:0] run_q;
  logic [4:0] pw_q;
  logic [2:0] wr_q;
  // limit is not visible here, so any disagreement is the weakest cause
  assign neq = i_can1_pos != i_analog_pos || i_can1_pos != i_can2_pos;
  // run length of disagreement, pwm sample and write history
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      run_q <= 8'h00;
      pw_q <= 5'h00;
      wr_q <= 3'h0;
    end else begin
      run_q <= !neq ? 8'h00 : run_q + {7'h00, run_q != 8'hff};
      pw_q <= {pw_q[3:0], i_pwm};
      wr_q <= {wr_q[1:0], i_req.wr};
    end
  end
  property p_speed_off; !o_flags.speed; endproperty
  a_speed_off: assert property (p_speed_off)
    else $error("speed fault raised");
  property p_trk_rise; $rose(o_flags.tracking) |-> run_q >= 8'(TICK_CYCLES);
  endproperty
  a_trk_rise: assert property (p_trk_rise)
    else $error("tracking alarm too early");
  property p_trk_fall; !neq |-> ##2 !o_flags.tracking; endproperty
  a_trk_fall: assert property (p_trk_fall)
    else $error("tracking alarm held");
  property p_pwm_upd;
    $changed(o_flags[3:0]) |-> |(pw_q[3:1] & ~pw_q[4:2]) || |wr_q;
  endproperty
  a_pwm_upd: assert property (p_pwm_upd)
    else $error("pwm flags moved without measurement");
  property p_duty_excl; !(o_flags.duty_hi && o_flags.duty_lo); endproperty
  a_duty_excl: assert property (p_duty_excl)
    else $error("duty high and low together");
  property p_freq_excl; !(o_flags.freq_hi && o_flags.freq_lo); endproperty
  a_freq_excl: assert property (p_freq_excl)
    else $error("frequency high and low together");
  property p_irq_src;
    $rose(o_irq) |-> $past(i_req.wr) ||
      |($past(o_flags) & ~$past(o_flags, 2)) ||
      |($past(o_flags, 2) & ~$past(o_flags, 3));
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("interrupt without event");
  property p_rd_idle; !$past(i_req.rd) |-> o_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_rd_flags;
    $past(i_req.rd) && $past(i_req.addr) == demand_mon_pkg::OFS_FLAGS |->
      o_rdata[5:0] == $past(o_flags);
  endproperty
  a_rd_flags: assert property (p_rd_flags)
    else $error("flag readback differs");
  c_duty: cover property ($rose(o_flags.duty_hi));
  c_trk: cover property ($rose(o_flags.tracking));
  c_irq: cover property ($rose(o_irq));
endmodule // demand_mon_asserts
////////////////////////////////////////
bind demand_mon demand_mon_asserts #(.TICK_CYCLES(TICK_CYCLES),
  .PERIOD_W(PERIOD_W), .POS_W(POS_W)) u_chk (.i_core_clk(i_core_clk),
  .i_resetn(i_resetn), .i_clk_en(i_clk_en), .i_req(i_req),
  .o_rdata(o_rdata), .i_pwm(i_pwm), .i_can1_pos(i_can1_pos),
  .i_can2_pos(i_can2_pos), .i_analog_pos(i_analog_pos),
  .o_flags(o_flags), .o_irq(o_irq));

/* tb/pwm_source.sv */
`timescale 1ns/10ps
module pwm_source (
  input wire logic i_core_clk,
  input wire logic [15:0] i_period,
  input wire logic [15:0] i_high,
  output logic o_pwm
);
  logic [15:0] cnt_q = 16'h0000;
  // a change of period cuts short or stretches the running one, so allow a settle period
  always @(posedge i_core_clk) begin
    if (cnt_q + 16'h0001 >= i_period) cnt_q <= 16'h0000;
    else cnt_q <= cnt_q + 16'h0001;
  end
  assign o_pwm = cnt_q < i_high;
endmodule // pwm_source

/* tb/demand_mon_bench.sv */
`timescale 1ns/10ps
module demand_mon_bench;
  localparam logic [7:0] OFS [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
    8'h14, 8'h20, 8'h2c};
  localparam logic [31:0] RST [8] = '{32'h1, 32'hf30d, 32'h1f4, 32'hbb8,
    32'h100, 32'h64, 32'h0, 32'h0};
  localparam int CP [7] = '{1599, 1600, 2000, 2001, 2048, 2048, 2048};
  localparam int CH [7] = '{800, 800, 1000, 1000, 1944, 104, 103};
  logic core_clk, resetn, pwm, irq;
  logic [15:0] can1, can2, ana, per, hi;
  logic [31:0] rdata, rv, seed;
  demand_mon_pkg::reg_req_t req;
  demand_mon_pkg::diag_flags_t flags;
  int fails, n_tests, p;
  int dmin = 13, dmax = 243, fmin = 50000, fmax = 62500;
  pwm_source u_src (.i_core_clk(core_clk), .i_period(per), .i_high(hi),
    .o_pwm(pwm));
  demand_mon #(.TICK_CYCLES(4)) DUT (.i_core_clk(core_clk),
    .i_resetn(resetn), .i_clk_en(1'b1), .i_req(req), .o_rdata(rdata),
    .i_pwm(pwm), .i_can1_pos(can1), .i_can2_pos(can2),
    .i_analog_pos(ana), .o_flags(flags), .o_irq(irq));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // freq_lo, freq_hi, duty_lo, duty_hi from clocks per period and high
  function automatic logic [3:0] exp_pwm(input int pp, input int h);
    return {100000000 < fmin * pp, 100000000 > fmax * pp,
      h * 256 < dmin * pp, h * 256 > dmax * pp};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // step past the edge so registered outputs have settled before a look
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // the #1 lets the write land before anything is looked at
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pos(input logic [15:0] a, b, c, input int n);
    @(posedge core_clk);
    can1 <= a;
    can2 <= b;
    ana <= c;
    cyc(n);
  endtask
  // three periods cover the cut period and one whole measurement
  task automatic pwm_case(input int pp, input int h);
    logic [3:0] e;
    per <= pp[15:0];
    hi <= h[15:0];
    cyc(3 * pp + 4);
    e = exp_pwm(pp, h);
    chk({28'h0, flags[3:0]}, {28'h0, e});
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    resetn = 1'b0;
    req = '0;
    per = 16'h0640;
    hi = 16'h0320;
    seed = 32'hc606cf53;
    fails = 0;
    n_tests = 0;
    pos(16'h0100, 16'h0100, 16'h0100, 8);
    resetn <= 1'b1;
    foreach (OFS[i]) begin
      rd(OFS[i], rv);
      chk(rv, RST[i]);
    end
    wr(demand_mon_pkg::OFS_FREQ_MIN, 32'h0000c350);
    wr(demand_mon_pkg::OFS_FREQ_MAX, 32'h0000f424);
    // random settings first, then exact limit boundaries
    for (int i = 0; i < 11; i++) begin
      seed = lfsr(seed);
      p = i < 4 ? 1550 + int'(seed[8:0]) : CP[i-4];
      pwm_case(p, i < 4 ? 1 + int'(seed[20:10]) % (p - 1) : CH[i-4]);
    end
    // interrupt: clear, mask, raise by a new duty-high event, clear
    wr(demand_mon_pkg::OFS_IRQ_STATUS, 32'h3f);
    rd(demand_mon_pkg::OFS_IRQ_STATUS, rv);
    chk(rv, 32'h0);
    wr(demand_mon_pkg::OFS_IRQ_MASK, 32'h1);
    chk({31'h0, irq}, 32'h0);
    pwm_case(2048, 1945);
    chk({31'h0, irq}, 32'h1);
    rd(demand_mon_pkg::OFS_IRQ_STATUS, rv);
    chk(rv & 32'h11, 32'h1);
    rd(demand_mon_pkg::OFS_FLAGS, rv);
    chk(rv, 32'h9);
    wr(demand_mon_pkg::OFS_IRQ_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    // tracking both signs of the difference, rise after 3 ticks
    wr(demand_mon_pkg::OFS_TRK_DIFF, 32'h10);
    wr(demand_mon_pkg::OFS_TRK_TIME, 32'h2);
    for (int i = 0; i < 2; i++) begin
      pos(16'h0100, 16'h0100, i ? 16'h00ef : 16'h0111, 10);
      chk({31'h0, flags.tracking}, 32'h0);
      cyc(10);
      chk({31'h0, flags.tracking}, 32'h1);
      pos(16'h0100, 16'h0100, 16'h0100, 3);
      chk({31'h0, flags.tracking}, 32'h0);
    end
    pos(16'h0100, 16'h0100, 16'h0110, 30);
    chk({31'h0, flags.tracking}, 32'h0);
    repeat (3) begin
      pos(16'h0100, 16'h0100, 16'h0100, 1);
      pos(16'h0100, 16'h0100, 16'h0111, 10);
    end
    chk({31'h0, flags.tracking}, 32'h0);
    wr(demand_mon_pkg::OFS_CTRL, 32'h3);
    pos(16'h0100, 16'h0130, 16'h0100, 20);
    chk({31'h0, flags.tracking}, 32'h1);
    pos(16'h0100, 16'h0100, 16'h0200, 20);
    chk({31'h0, flags.tracking}, 32'h0);
    // disabled monitor holds every flag low
    wr(demand_mon_pkg::OFS_CTRL, 32'h0);
    pos(16'h0100, 16'h0100, 16'h0200, 4);
    chk({26'h0, flags}, 32'h0);
    tally_and_finish;
  end
endmodule // demand_mon_bench
